// >>> hdl/mcc_pkg.sv
// Constants and types shared by both ends of the machine check link
package mcc_pkg;
  localparam int unsigned MCC_CLK_PERIOD_NS = 8;
  localparam int unsigned MCC_MC_HOLD_CYC   = 2;
  localparam logic [1:0]  MCC_CNT_RESET     = 2'h0;
  localparam logic        MCC_EN_RESET      = 1'h0;
  localparam logic        MCC_FLAG_RESET    = 1'h0;
  localparam logic        MCC_DRV_RESET     = 1'h1;
  localparam logic        MCC_PIN_IDLE      = 1'h1;
  localparam int unsigned MCC_PIN_MC        = 0;
  localparam int unsigned MCC_PIN_CKI       = 1;
  localparam int unsigned MCC_PIN_CNT       = 2;

  typedef enum logic [1:0] {
    MCC_RUN,
    MCC_STOPPED
  } mcc_state_t;
endpackage : mcc_pkg

// >>> hdl/mcc_if.sv
// Interface joining the core end and the system end
`timescale 1ns/10ps
interface mcc_if;
  logic mc_n;
  logic ckstp_in_n;
  logic ckstp_out_n;
  logic ckstp_oe;
  logic ckstp_tre;

  modport core (
    input  mc_n,
    input  ckstp_in_n,
    input  ckstp_tre,
    output ckstp_out_n,
    output ckstp_oe
  );
  modport sys (
    output mc_n,
    output ckstp_in_n,
    output ckstp_tre,
    input  ckstp_out_n,
    input  ckstp_oe
  );
endinterface : mcc_if

// >>> hdl/mcc_core.sv
// Core end: machine check and checkstop handling
`timescale 1ns/10ps
module mcc_core
  import mcc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  mcc_if.core       link,
  input  wire logic machine_check_enable_bit,
  input  wire logic external_mc_pin_enable_bit,
  output logic      mc_exception,
  output logic      core_stopped,
  output logic      outputs_float,
  output logic      ckstp_drive_en
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Both pins may move at any time: two flops each
  wire logic [MCC_PIN_CNT-1:0] pin_raw;
  wire logic [MCC_PIN_CNT-1:0] pin_sync;

  assign pin_raw[MCC_PIN_MC]  = link.mc_n;
  assign pin_raw[MCC_PIN_CKI] = link.ckstp_in_n;

  for (genvar i = 0; i < MCC_PIN_CNT; i++) begin : g_sync
    logic meta_q, meta_d;
    logic sync_q, sync_d;

    always_comb begin
      meta_d = pin_raw[i];
      sync_d = meta_q;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        meta_q <= MCC_PIN_IDLE;
        sync_q <= MCC_PIN_IDLE;
      end else begin
        meta_q <= meta_d;
        sync_q <= sync_d;
      end
    end

    assign pin_sync[i] = sync_q;
  end

  // ----------------------------------------------------------------
  // Machine check edge detector
  // ----------------------------------------------------------------
  // Idle-high start: no false edge after reset
  logic mc_prev_q, mc_prev_d;
  logic mc_fall;

  always_comb begin
    mc_prev_d = pin_sync[MCC_PIN_MC];
    mc_fall   = mc_prev_q && !pin_sync[MCC_PIN_MC];
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mc_prev_q <= MCC_PIN_IDLE;
    end else begin
      mc_prev_q <= mc_prev_d;
    end
  end

  // ----------------------------------------------------------------
  // Tri-state enable capture
  // ----------------------------------------------------------------
  // Static strap, same clock as the system end
  logic tre_q, tre_d;

  always_comb begin
    tre_d = link.ckstp_tre;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tre_q <= MCC_EN_RESET;
    end else begin
      tre_q <= tre_d;
    end
  end

  // ----------------------------------------------------------------
  // Stop request decode
  // ----------------------------------------------------------------
  // Checkstop input outranks a machine check edge
  logic stop_req;
  logic exc_req;

  always_comb begin
    stop_req = 1'h0;
    exc_req  = 1'h0;
    if (!pin_sync[MCC_PIN_CKI]) begin
      stop_req = 1'h1;
    end else if (mc_fall && external_mc_pin_enable_bit) begin
      if (machine_check_enable_bit) begin
        exc_req = 1'h1;
      end else begin
        stop_req = 1'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Stop state
  // ----------------------------------------------------------------
  mcc_state_t state_q, state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      MCC_RUN: begin
        if (stop_req) begin
          state_d = MCC_STOPPED;
        end
      end
      MCC_STOPPED: begin
        state_d = MCC_STOPPED;
      end
      default: begin
        state_d = MCC_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= MCC_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Machine check exception
  // ----------------------------------------------------------------
  // One-cycle pulse; a stopped core takes none
  logic exc_q, exc_d;

  always_comb begin
    exc_d = exc_req && (state_q == MCC_RUN);
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      exc_q <= MCC_FLAG_RESET;
    end else begin
      exc_q <= exc_d;
    end
  end

  // ----------------------------------------------------------------
  // Clock gating and output float
  // ----------------------------------------------------------------
  // Both stay set until hard reset
  logic halt_q,  halt_d;
  logic float_q, float_d;

  always_comb begin
    halt_d  = (state_d == MCC_STOPPED);
    float_d = (state_d == MCC_STOPPED);
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      halt_q  <= MCC_FLAG_RESET;
      float_q <= MCC_FLAG_RESET;
    end else begin
      halt_q  <= halt_d;
      float_q <= float_d;
    end
  end

  // ----------------------------------------------------------------
  // Checkstop output pin
  // ----------------------------------------------------------------
  // Value and valid flag move together; driver enable follows them only while tre_q is set, else stays on
  logic out_q, out_d;
  logic oe_q,  oe_d;
  logic drv_q, drv_d;

  always_comb begin
    out_d = (state_d == MCC_STOPPED) ? 1'h0 : 1'h1;
    oe_d  = (state_d == MCC_STOPPED);
    drv_d = tre_q ? oe_d : 1'h1;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_q <= MCC_PIN_IDLE;
      oe_q  <= MCC_FLAG_RESET;
      drv_q <= MCC_DRV_RESET;
    end else begin
      out_q <= out_d;
      oe_q  <= oe_d;
      drv_q <= drv_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.ckstp_out_n = out_q;
  assign link.ckstp_oe    = oe_q;
  assign mc_exception     = exc_q;
  assign core_stopped     = halt_q;
  assign outputs_float    = float_q;
  assign ckstp_drive_en   = drv_q;
endmodule : mcc_core

// >>> hdl/mcc_sys.sv
// System end: drives machine check, checkstop and tri-state enable
`timescale 1ns/10ps
module mcc_sys
  import mcc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  mcc_if.sys        link,
  input  wire logic mc_req,
  input  wire logic ckstp_req,
  input  wire logic tre_cfg,
  output logic      mc_busy,
  output logic      core_ckstp_seen
);
  // ----------------------------------------------------------------
  // Drive logic
  // ----------------------------------------------------------------
  logic [1:0] cnt_q,  cnt_d;
  logic       ck_q,   ck_d;
  logic       tre_q,  tre_d;
  logic [1:0] so_q,   so_d;
  logic       cfg_q,  cfg_d;
  logic       mcn_q,  mcn_d;
  logic       busy_q, busy_d;

  always_comb begin
    so_d  = {so_q[0], ~link.ckstp_out_n & link.ckstp_oe};
    cnt_d = cnt_q;
    if (cnt_q != MCC_CNT_RESET) begin
      cnt_d = cnt_q - 2'h1;
    end else if (mc_req) begin
      cnt_d = 2'(MCC_MC_HOLD_CYC);
    end
    mcn_d  = (cnt_d == MCC_CNT_RESET);
    busy_d = (cnt_d != MCC_CNT_RESET);
    ck_d  = ck_q | ckstp_req;
    tre_d = tre_q;
    cfg_d = 1'h1;
    if (!cfg_q) begin
      tre_d = tre_cfg;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= MCC_CNT_RESET;
      ck_q  <= 1'h0;
      mcn_q  <= MCC_PIN_IDLE;
      busy_q <= MCC_FLAG_RESET;
      so_q  <= 2'h0;
      cfg_q <= 1'h0;
    end else begin
      cnt_q <= cnt_d;
      ck_q  <= ck_d;
      mcn_q  <= mcn_d;
      busy_q <= busy_d;
      so_q  <= so_d;
      cfg_q <= cfg_d;
    end
  end

  // No reset: follows tre_cfg all through reset
  always_ff @(posedge core_clk) begin
    tre_q <= tre_d;
  end

  assign link.mc_n       = mcn_q;
  assign link.ckstp_in_n = ~ck_q;
  assign link.ckstp_tre  = tre_q;
  assign mc_busy         = busy_q;
  assign core_ckstp_seen = so_q[1];
endmodule : mcc_sys

// >>> verif/mcc_monitor.sv
// Checker on the link between core end and system end
`timescale 1ns/10ps
module mcc_monitor (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic mc_n,
  input wire logic ckstp_in_n,
  input wire logic ckstp_out_n,
  input wire logic ckstp_oe,
  input wire logic ckstp_tre
);
  logic cause_q;
  // Sticky: some stop cause seen since reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) cause_q <= 1'h0;
    else if (!mc_n || !ckstp_in_n) cause_q <= 1'h1;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  AST_MC_HOLD: assert property ($fell(mc_n) |=> !mc_n)
    else $error("machine check held under two cycles");
  AST_IN_HELD: assert property (!ckstp_in_n |=> !ckstp_in_n)
    else $error("checkstop input released before reset");
  AST_IN_STOPS: assert property ($fell(ckstp_in_n) |-> ##[1:6] !ckstp_out_n)
    else $error("checkstop input did not stop core");
  AST_STOP_STAYS: assert property (!ckstp_out_n |=> !ckstp_out_n)
    else $error("checkstop left without reset");
  AST_STOP_CAUSE: assert property (!ckstp_out_n |-> cause_q)
    else $error("checkstop output without cause");
  AST_OE_VALID: assert property (ckstp_oe == !ckstp_out_n)
    else $error("output enable not tied to checkstop");
  AST_TRE_STATIC: assert property ($past(reset_n) |-> $stable(ckstp_tre))
    else $error("tri-state enable changed in operation");
  AST_RST_NEG: assert property (disable iff (1'b0) !reset_n |-> ckstp_out_n && !ckstp_oe)
    else $error("checkstop output active in reset");
endmodule : mcc_monitor

// >>> verif/mcc_tb.sv
// Self-checking bench for the machine check link
`timescale 1ns/10ps
module mcc_tb;
  import mcc_pkg::*;
  logic core_clk = 1'h0;
  logic reset_n = 1'h1;
  logic mc_req = 1'h0, ckstp_req = 1'h0, tre_cfg = 1'h0;
  logic en_chk = 1'h0, en_pin = 1'h0;
  logic mc_exception, core_stopped, outputs_float, ckstp_drive_en, seen, busy;
  int error_cnt = 0, checks_done = 0, exc_n = 0, cyc = 0;
  mcc_if link ();
  wire logic [7:0] stat = {2'h0, seen, outputs_float, core_stopped,
                           link.ckstp_out_n, link.ckstp_oe, ckstp_drive_en};
  mcc_core mcc_core_inst (.core_clk(core_clk), .reset_n(reset_n),
    .link(link.core), .machine_check_enable_bit(en_chk),
    .external_mc_pin_enable_bit(en_pin), .mc_exception(mc_exception),
    .core_stopped(core_stopped), .outputs_float(outputs_float),
    .ckstp_drive_en(ckstp_drive_en));
  mcc_sys mcc_sys_inst (.core_clk(core_clk), .reset_n(reset_n),
    .link(link.sys), .mc_req(mc_req), .ckstp_req(ckstp_req),
    .tre_cfg(tre_cfg), .mc_busy(busy), .core_ckstp_seen(seen));
  mcc_monitor mcc_monitor_inst (.core_clk(core_clk), .reset_n(reset_n),
    .mc_n(link.mc_n), .ckstp_in_n(link.ckstp_in_n),
    .ckstp_out_n(link.ckstp_out_n), .ckstp_oe(link.ckstp_oe),
    .ckstp_tre(link.ckstp_tre));
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (mc_exception === 1'h1) exc_n <= exc_n + 1;
    if (cyc == 1000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic do_reset(input logic tre, input logic ec, input logic ep);
    reset_n = 1'h0;
    tre_cfg = tre;
    en_chk = ec;
    en_pin = ep;
    exc_n = 0;
    repeat (12) @(posedge core_clk);
    check(stat, 8'h05);
    #1 reset_n = 1'h1;
  endtask : do_reset
  task automatic pulse(input bit stop_req);
    @(posedge core_clk) #1;
    if (stop_req) ckstp_req = 1'h1;
    else mc_req = 1'h1;
    @(posedge core_clk) #1;
    ckstp_req = 1'h0;
    mc_req = 1'h0;
    check({6'h0, busy, link.mc_n}, stop_req ? 8'h01 : 8'h02);
    repeat (12) @(posedge core_clk);
    #1;
  endtask : pulse
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  initial begin
    #1;
    do_reset(1'h0, 1'h1, 1'h0);
    pulse(0);
    check(8'(exc_n), 8'h00);
    check(stat, 8'h05);
    en_pin = 1'h1;
    pulse(0);
    pulse(0);
    check(8'(exc_n), 8'h02);
    en_chk = 1'h0;
    pulse(0);
    check(stat, 8'h3B);
    en_chk = 1'h1;
    pulse(0);
    check(8'(exc_n), 8'h02);
    check(stat, 8'h3B);
    $display("test mc done");
    do_reset(1'h1, 1'h1, 1'h1);
    pulse(0);
    check(stat, 8'h04);
    check(8'(exc_n), 8'h01);
    pulse(1);
    check(stat, 8'h3B);
    $display("test stop done");
    give_verdict();
  end
endmodule : mcc_tb
